// [core/led_dim_defs.vh]
// Constants for the LED dimming pulse controller
`ifndef LED_DIM_DEFS_VH
`define LED_DIM_DEFS_VH
// Register byte offsets
`define OFF_CTRL 4'h0
`define OFF_FREE_DIV 4'h4
`define OFF_FRAME_MULT 4'h8
`define OFF_STATUS 4'hC
// Control register field positions
`define CTRL_FRAME_EN 0
`define CTRL_PHASE_EN 1
// Reset values
`define RST_CTRL 2'h0
`define RST_FREE_DIV 16'h0028
`define RST_FRAME_MULT 4'h3
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Dimming period: 1024 steps, full scale duty word
`define STEP_BITS 10
`define DUTY_FULL 11'h400
`define QUARTER_STEP 10'h100
// Analog level window in millivolts, 8-bit full code
`define ADIM_MV_LOW 12'h12C
`define ADIM_MV_HIGH 12'hBB8
`define ADIM_MV_SPAN 20'h0_0A8C
`define ADIM_CODE_MAX 8'hFF
`define ADIM_SCALE_FULL 9'h100
`endif

// [core/pulse_duty_decoder.v]
// Measures the duty of the dimming pulse input as a fraction of 1024
`timescale 1ns/1ps
`default_nettype none
module pulse_duty_decoder #(
    parameter CNT_W = 21,
    parameter TIMEOUT = 21'h10_0000
)(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Synchronised pulse
    input wire pulse_in,
    // Decoded duty, 1024 = always on
    output reg [10:0] duty_q
);
`include "led_dim_defs.vh"
    localparam DW = CNT_W + `STEP_BITS;
    reg prev_q; // Previous pulse level
    reg [CNT_W-1:0] period_q; // Cycles since last rising edge
    reg [CNT_W-1:0] high_q; // High cycles in that span
    reg busy_q; // Divider running
    reg [7:0] steps_q; // Divider bits left
    reg [DW-1:0] dvd_q; // Dividend shifter
    reg [CNT_W-1:0] dvs_q; // Divisor
    reg [CNT_W-1:0] rem_q; // Partial remainder
    reg [DW-1:0] quo_q; // Quotient
    wire rise = pulse_in & ~prev_q;
    wire [CNT_W:0] rem_sh = {rem_q, dvd_q[DW-1]};
    wire fit = rem_sh >= {1'b0, dvs_q};
    wire [CNT_W:0] rem_sub = rem_sh - {1'b0, dvs_q};
    wire [DW-1:0] quo_nx = {quo_q[DW-2:0], fit};

    // Period and high time, restart on each rising edge while the divider is idle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_q <= 1'b0;
            period_q <= {CNT_W{1'b0}};
            high_q <= {CNT_W{1'b0}};
            busy_q <= 1'b0;
            steps_q <= 8'h00;
            dvd_q <= {DW{1'b0}};
            dvs_q <= {CNT_W{1'b0}};
            rem_q <= {CNT_W{1'b0}};
            quo_q <= {DW{1'b0}};
            duty_q <= 11'h000;
        end
        else
        begin
            prev_q <= pulse_in;
            if (rise && !busy_q)
            begin
                // Full period seen, divide high by period
                busy_q <= 1'b1;
                steps_q <= DW[7:0];
                dvd_q <= {high_q, {`STEP_BITS{1'b0}}};
                dvs_q <= period_q;
                rem_q <= {CNT_W{1'b0}};
                quo_q <= {DW{1'b0}};
                period_q <= {{(CNT_W-1){1'b0}}, 1'b1};
                high_q <= {{(CNT_W-1){1'b0}}, 1'b1};
            end
            else if (period_q == TIMEOUT)
            begin
                // No edges: a static level is 0% or 100%
                duty_q <= pulse_in ? `DUTY_FULL : 11'h000;
                period_q <= {CNT_W{1'b0}};
                high_q <= {CNT_W{1'b0}};
            end
            else
            begin
                period_q <= period_q + 1'b1;
                high_q <= high_q + {{(CNT_W-1){1'b0}}, pulse_in};
            end
            // One quotient bit per cycle; slow but tiny
            if (busy_q)
            begin
                rem_q <= fit ? rem_sub[CNT_W-1:0] : rem_sh[CNT_W-1:0];
                quo_q <= quo_nx;
                dvd_q <= {dvd_q[DW-2:0], 1'b0};
                steps_q <= steps_q - 8'h01;
                if (steps_q == 8'h01)
                begin
                    busy_q <= 1'b0;
                    duty_q <= (quo_nx > {{(DW-11){1'b0}}, `DUTY_FULL}) ?
                        `DUTY_FULL : quo_nx[10:0];
                end
            end
        end
    end
endmodule // pulse_duty_decoder
`default_nettype wire

// [core/led_dim_pwm.v]
// LED dimming pulse control with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module led_dim_pwm #(
    parameter FRAME_W = 24,
    parameter DEC_CNT_W = 21,
    parameter DEC_TIMEOUT = 21'h10_0000
)(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Dimming pins, asynchronous
    input wire dimming_pulse_input,
    input wire current_level_select,
    input wire analog_dim_enable,
    input wire freq_set_tied_high,
    input wire frame_start,
    // Analog level from converter, same clock
    input wire [11:0] analog_level_input,
    // LED outputs
    output reg [3:0] led_channel_pin,
    output reg current_set_second
);
`include "led_dim_defs.vh"

    // Two-stage synchronisers for the five asynchronous dimming pins
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end
        else
        begin
            sync1_q <= {frame_start, freq_set_tied_high, analog_dim_enable,
                current_level_select, dimming_pulse_input};
            sync2_q <= sync1_q;
        end
    end
    wire pulse_s = sync2_q[0]; // Dimming pulse
    wire current_level_select_s = sync2_q[1]; // Current level select
    wire adim_s = sync2_q[2]; // Analog enable
    wire direct_s = sync2_q[3]; // Direct mode strap
    wire frame_s = sync2_q[4]; // Frame timing

    // Registers
    reg [1:0] ctrl_q; // Frame lock, phase shift enables
    reg [15:0] free_div_q; // Clocks per step, free mode
    reg [3:0] frame_mult_q; // Periods per frame
    reg [10:0] duty_act_q; // Duty of current period
    reg [7:0] adim_code_q; // Decoded analog level
    reg frame_prev_q; // Frame edge detect
    reg [FRAME_W-1:0] frame_cnt_q; // Clocks in this frame
    reg [FRAME_W-1:0] frame_len_q; // Last frame length
    reg [FRAME_W-1:0] acc_q; // Step accumulator
    reg [9:0] pos_q; // Position in dimming period
    wire [10:0] pwm_duty; // Decoded pulse duty

    // Pulse duty measurement
    pulse_duty_decoder #(
        .CNT_W(DEC_CNT_W),
        .TIMEOUT(DEC_TIMEOUT)
    ) u_dec (
        .aclk(aclk),
        .aresetn(aresetn),
        .pulse_in(pulse_s),
        .duty_q(pwm_duty)
    );

    // Analog level to 8-bit code, clamped outside the window
    wire [11:0] mv_off = analog_level_input - `ADIM_MV_LOW;
    wire [19:0] mv_scaled = {8'h00, mv_off} * {12'h000, `ADIM_CODE_MAX};
    wire [19:0] mv_code = mv_scaled / `ADIM_MV_SPAN;
    always @(posedge aclk)
    begin
        if (!aresetn)
            adim_code_q <= 8'h00;
        else if (analog_level_input <= `ADIM_MV_LOW)
            adim_code_q <= 8'h00;
        else if (analog_level_input >= `ADIM_MV_HIGH)
            adim_code_q <= `ADIM_CODE_MAX;
        else
            adim_code_q <= mv_code[7:0];
    end

    // Duty source: pulse alone, or pulse times analog level
    wire [8:0] adim_scale = (adim_code_q == `ADIM_CODE_MAX) ?
        `ADIM_SCALE_FULL : {1'b0, adim_code_q};
    wire [19:0] prod = {9'h000, pwm_duty} * {11'h000, adim_scale};
    wire [10:0] duty_src = adim_s ? prod[18:8] : pwm_duty;

    // Step rate: free divider or frame-locked fraction
    wire frame_en = ctrl_q[`CTRL_FRAME_EN];
    wire phase_en = ctrl_q[`CTRL_PHASE_EN];
    wire frame_edge = frame_s & ~frame_prev_q;
    wire [FRAME_W-1:0] inc = frame_en ?
        {{(FRAME_W-14){1'b0}}, frame_mult_q, 10'h000} :
        {{(FRAME_W-1){1'b0}}, 1'b1};
    wire [FRAME_W-1:0] thr = frame_en ? frame_len_q :
        {{(FRAME_W-16){1'b0}}, free_div_q};
    wire [FRAME_W-1:0] thr_g = (thr == {FRAME_W{1'b0}}) ?
        {{(FRAME_W-1){1'b0}}, 1'b1} : thr;
    wire [FRAME_W:0] acc_sum = {1'b0, acc_q} + {1'b0, inc};
    wire step = acc_sum >= {1'b0, thr_g};
    wire [FRAME_W:0] acc_left = acc_sum - {1'b0, thr_g};
    wire restart = frame_en & frame_edge;
    wire period_start = restart | (step & (pos_q == 10'h3FF));

    // Period counter; frame edge re-aligns phase in lock mode
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            frame_prev_q <= 1'b0;
            frame_cnt_q <= {FRAME_W{1'b0}};
            frame_len_q <= {FRAME_W{1'b1}};
            acc_q <= {FRAME_W{1'b0}};
            pos_q <= 10'h000;
        end
        else
        begin
            frame_prev_q <= frame_s;
            if (frame_edge)
            begin
                // Length counts the edge cycle itself
                frame_len_q <= frame_cnt_q + 1'b1;
                frame_cnt_q <= {FRAME_W{1'b0}};
            end
            else if (frame_cnt_q != {FRAME_W{1'b1}})
                frame_cnt_q <= frame_cnt_q + 1'b1;
            if (restart)
            begin
                acc_q <= {FRAME_W{1'b0}};
                pos_q <= 10'h000;
            end
            else if (step)
            begin
                // Short frames may lag; the accumulator then grows and can wrap past its width
                acc_q <= acc_left[FRAME_W-1:0];
                pos_q <= pos_q + 10'h001;
            end
            else
                acc_q <= acc_sum[FRAME_W-1:0];
        end
    end

    // New duty only at period start; current select at period start, or at once in direct mode
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            duty_act_q <= 11'h000;
            current_set_second <= 1'b0;
        end
        else
        begin
            if (period_start)
                duty_act_q <= duty_src;
            if (direct_s)
                current_set_second <= current_level_select_s;
            else if (period_start)
                current_set_second <= current_level_select_s;
        end
    end

    // Channel windows: compare position, optional quarter stagger
    reg [3:0] led_d;
    integer ch;
    always @*
    begin
        led_d = 4'h0;
        for (ch = 0; ch < 4; ch = ch + 1)
        begin
            if (direct_s)
                led_d[ch] = pulse_s;
            else if (phase_en)
                led_d[ch] = {1'b0, pos_q - ch[1:0] * `QUARTER_STEP}
                    < duty_act_q;
            else
                led_d[ch] = {1'b0, pos_q} < duty_act_q;
        end
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
            led_channel_pin <= 4'h0;
        else
            led_channel_pin <= led_d;
    end

    // AXI write channel: address and data may arrive in any order
    reg aw_have_q;
    reg w_have_q;
    reg [3:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
    wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire wr_hit = (aw_addr_q == `OFF_CTRL) |
        (aw_addr_q == `OFF_FREE_DIV) | (aw_addr_q == `OFF_FRAME_MULT);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ctrl_q <= `RST_CTRL;
            free_div_q <= `RST_FREE_DIV;
            frame_mult_q <= `RST_FRAME_MULT;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_addr_q == `OFF_CTRL && w_strb_q[0])
                    ctrl_q <= w_data_q[1:0];
                if (aw_addr_q == `OFF_FREE_DIV)
                begin
                    if (w_strb_q[0])
                        free_div_q[7:0] <= w_data_q[7:0];
                    if (w_strb_q[1])
                        free_div_q[15:8] <= w_data_q[15:8];
                end
                if (aw_addr_q == `OFF_FRAME_MULT && w_strb_q[0])
                    frame_mult_q <= w_data_q[3:0];
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read channel: one cycle to answer
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `OFF_CTRL: s_axi_rdata <= {30'h0000_0000, ctrl_q};
                `OFF_FREE_DIV: s_axi_rdata <= {16'h0000, free_div_q};
                `OFF_FRAME_MULT: s_axi_rdata <= {28'h000_0000, frame_mult_q};
                `OFF_STATUS: s_axi_rdata <= {adim_code_q, pwm_duty,
                    current_set_second, direct_s, duty_act_q};
                default:
                begin
                    // Unmapped word reads zero with an error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // led_dim_pwm
`default_nettype wire

// [verification/led_dim_pwm_asserts.sv]
// Bus and pin-level checks for the LED dimming controller
`timescale 1ns/1ps
`default_nettype none
module led_dim_pwm_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Dimming pins
    input wire logic dimming_pulse_input,
    input wire logic current_level_select,
    input wire logic freq_set_tied_high,
    input wire logic [3:0] led_channel_pin,
    input wire logic current_set_second
);
    // One clock domain, one reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_write_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not blocked");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
        |=> s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_status_refused: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr[3:2] == 2'b11
        |-> ##[1:20] s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("status write accepted");
    a_direct_copy: assert property (
        (freq_set_tied_high && $stable(dimming_pulse_input))[*5]
        |-> led_channel_pin == {4{dimming_pulse_input}})
        else $error("direct copy wrong");
    a_direct_select: assert property (
        (freq_set_tied_high && $stable(current_level_select))[*5]
        |-> current_set_second == current_level_select)
        else $error("select not immediate");
endmodule // led_dim_pwm_asserts
bind led_dim_pwm led_dim_pwm_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dimming_pulse_input(dimming_pulse_input),
    .current_level_select(current_level_select),
    .freq_set_tied_high(freq_set_tied_high),
    .led_channel_pin(led_channel_pin),
    .current_set_second(current_set_second)
);
`default_nettype wire

// [verification/dim_host_model.sv]
// Host model: dimming pulse train and frame start pulses
`timescale 1ns/1ps
`default_nettype none
module dim_host_model (
    // Clock
    input wire logic aclk,
    // Shape, in clocks
    input wire logic [15:0] high_len,
    input wire logic [15:0] low_len,
    input wire logic hold_high,
    input wire logic [15:0] frame_len,
    // Pins to the block
    output var logic pulse,
    output var logic frame
);
    logic [15:0] pcnt = 16'h0000;
    logic [15:0] fcnt = 16'h0000;
    initial pulse = 1'b0;
    initial frame = 1'b0;
    // Pulse train; held high to skip the divide
    always @(posedge aclk)
    begin
        if (hold_high)
            pulse <= 1'b1;
        else if (pcnt + 16'h0001 >= (pulse ? high_len : low_len))
        begin
            pulse <= !pulse;
            pcnt <= 16'h0000;
        end
        else
            pcnt <= pcnt + 16'h0001;
    end
    // Frame start, 8 clocks wide; zero length stops it
    always @(posedge aclk)
    begin
        if (frame_len == 16'h0000 || fcnt + 16'h0001 >= frame_len)
            fcnt <= 16'h0000;
        else
            fcnt <= fcnt + 16'h0001;
        frame <= (frame_len != 16'h0000) && (fcnt < 16'h0008);
    end
endmodule // dim_host_model
`default_nettype wire

// [verification/test_led_dimming_pwm_control.sv]
// Self-checking bench for the LED dimming controller
`timescale 1ns/1ps
`default_nettype none
module test_led_dimming_pwm_control;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, led;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, set2, hold;
    logic pulse, sel, aden, fset, frame;
    logic [11:0] mv;
    logic [15:0] hi_len, lo_len, fr_len;
    int miscompares, checked, n, m;
    int cycles = 0;
    led_dim_pwm #(.DEC_TIMEOUT(21'h0400)) u_dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .dimming_pulse_input(pulse), .current_level_select(sel),
        .analog_dim_enable(aden), .freq_set_tied_high(fset),
        .frame_start(frame), .analog_level_input(mv),
        .led_channel_pin(led), .current_set_second(set2));
    dim_host_model u_host (.aclk(aclk), .high_len(hi_len),
        .low_len(lo_len), .hold_high(hold), .frame_len(fr_len),
        .pulse(pulse), .frame(frame));
    // 40 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Bus write: hold each channel until taken, then wait for response
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    // Clocks until channel k shows level v
    task automatic wait_led(input int k, input logic v, output int c);
        c = 0;
        do
        begin
            @(posedge aclk);
            c = c + 1;
        end
        while (led[k] !== v);
    endtask
    task automatic t_regs;
        axi_rd(4'h0);
        check(rd, 32'h0000_0000);
        axi_rd(4'h4);
        check(rd, 32'h0000_0028);
        axi_rd(4'h8);
        check(rd, 32'h0000_0003);
        axi_wr(4'hC, 32'hFFFF_FFFF, 4'hF);
        check(resp, 2'h2);
        // Lane 0 only: one clock per step
        axi_wr(4'h4, 32'h1234_5601, 4'h1);
        axi_rd(4'h4);
        check(rd, 32'h0000_0001);
    endtask
    task automatic t_free;
        int c [4];
        c = '{default: 0};
        repeat (3000) @(posedge aclk);
        axi_rd(4'hC);
        check(rd[23:13], 11'h100);
        check(rd[11:0], 12'h100);
        repeat (1024)
        begin
            @(posedge aclk);
            for (int k = 0; k < 4; k++)
                c[k] = c[k] + led[k];
        end
        for (int k = 0; k < 4; k++)
            check(c[k], 32'h0000_0100);
    endtask
    task automatic t_sel;
        // Start at the falling edge so the next period is far off
        wait_led(0, 1'b1, n);
        wait_led(0, 1'b0, n);
        sel <= 1'b0;
        repeat (100) @(posedge aclk);
        check(set2, 1'b1);
        wait_led(0, 1'b1, n);
        repeat (2) @(posedge aclk);
        check(set2, 1'b0);
    endtask
    task automatic t_phase;
        axi_wr(4'h0, 32'h0000_0002, 4'hF);
        repeat (2100) @(posedge aclk);
        wait_led(0, 1'b0, n);
        wait_led(0, 1'b1, n);
        wait_led(1, 1'b1, n);
        check(n, 32'h0000_0100);
        check(led, 4'h2);
    endtask
    task automatic t_analog;
        logic [11:0] mvs [3] = '{12'h0C8, 12'hBB8, 12'h672};
        logic [7:0] cds [3] = '{8'h00, 8'hFF, 8'h7F};
        for (int i = 0; i < 3; i++)
        begin
            mv <= mvs[i];
            repeat (4) @(posedge aclk);
            axi_rd(4'hC);
            check(rd[31:24], cds[i]);
        end
        aden <= 1'b1;
        repeat (3000) @(posedge aclk);
        axi_rd(4'hC);
        check(rd[10:0], 11'h07F);
        hold <= 1'b1;
        repeat (4000) @(posedge aclk);
        axi_rd(4'hC);
        check(rd[23:0], 24'h80_01FC);
        hold <= 1'b0;
        aden <= 1'b0;
    endtask
    task automatic t_frame;
        axi_wr(4'h0, 32'h0000_0001, 4'hF);
        fr_len <= 16'h0C00;
        repeat (13000) @(posedge aclk);
        wait_led(0, 1'b0, n);
        wait_led(0, 1'b1, n);
        wait_led(0, 1'b0, n);
        wait_led(0, 1'b1, m);
        check(n + m, 32'h0000_0400);
        for (int i = 0; i < 2; i++)
        begin
            do @(posedge aclk); while (frame !== 1'b0);
            do @(posedge aclk); while (frame !== 1'b1);
            wait_led(0, 1'b1, m);
            if (i == 0)
                n = m;
        end
        check(m, n);
    endtask
    task automatic t_direct;
        axi_wr(4'h0, 32'h0000_0003, 4'hF);
        hi_len <= 16'h000A;
        lo_len <= 16'h000A;
        fset <= 1'b1;
        repeat (20) @(posedge aclk);
        do @(posedge aclk); while (pulse !== 1'b1);
        repeat (5) @(posedge aclk);
        check(led, 4'hF);
        sel <= 1'b1;
        repeat (4) @(posedge aclk);
        check(set2, 1'b1);
    endtask
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, aden, fset, hold} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        hi_len = 16'h0064;
        lo_len = 16'h012C;
        fr_len = 16'h0000;
        sel = 1'b1;
        mv = 12'h672;
        miscompares = 0;
        checked = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_free;
        t_sel;
        t_phase;
        t_analog;
        t_frame;
        t_direct;
        print_verdict;
    end
endmodule // test_led_dimming_pwm_control
`default_nettype wire
